/* File: design/sfq_front_end.sv */
`timescale 1ns/1ns
// Overview of operation
// - single line: sample rising, drive falling
// - clock modes 0 and 3 both work
// - dual opcodes use two bidirectional lines
// - quad opcodes use four lines, need quad_enable
// - 38h enters four-wire mode with quad_enable, FFh leaves
// - four-wire opcode in two clocks, else eight
// - power-up and soft reset give SPI mode
// - DTR: opcode on rise, then both edges
// - power-up address width from strap bit
// - B7h/E9h switch width, status shows it
// - 3-byte mode adds extended address byte
// - dedicated opcodes always take four bytes
// - pause only with quad_enable low
// - pause starts when clock is low
// - pause ends when clock is low
// - paused: outputs off, inputs ignored, state kept
// - 66h then 99h resets, busy 30us
// - select bit picks pause or reset role
// - reset low 1us restores power-on state
// - dedicated reset pin works regardless settings
// - quad_enable makes shared pin data only
// - deselected: data outputs tri-stated
module sfq_front_end #(
    parameter int SW_RESET_CYCLES = sfq_pkg::SW_RESET_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sclkPin,            // serial clock from host
    input wire logic selectPinN,         // select, active low
    input wire logic resetPinN,          // dedicated reset pin
    input wire logic [3:0] ioIn,         // data line levels
    output logic [3:0] ioOut,            // data line drive values
    output logic [3:0] ioOe,             // data line enables
    input wire logic quadEnable,         // quad_enable setting
    input wire logic pauseOrResetSel,    // shared pin role
    input wire logic addrWidthAtPowerup, // 1 = 4-byte at power-up
    input wire logic [7:0] extAddr,      // extended address register
    input wire logic [7:0] readData,     // next read byte from array
    output logic readTake,               // readData consumed
    output logic cmdValid,               // opcode accepted
    output logic [7:0] cmdOpcode,
    output logic addrValid,              // address complete
    output logic [31:0] cmdAddr,
    output logic fourWireOpcodeMode,
    output logic addrWidthNow,
    output logic resetBusy,
    output logic pauseActive
);
    // ------------------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------------------
    logic [1:0] rstSync_q;  // async set low, released over two edges
    logic rstN;
    sfq_pin_if pins ();

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    sfq_pin_sync u_sync (
        .clk(clk),
        .rstN(rstN),
        .sclkPin(sclkPin),
        .selectPinN(selectPinN),
        .resetPinN(resetPinN),
        .ioIn(ioIn),
        .pins(pins)
    );

    // ------------------------------------------------------------------------
    // opcode decoding
    // ------------------------------------------------------------------------
    function automatic logic isRead(input logic [7:0] op);
        case (op)
            8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'h0D, 8'hBD, 8'hED,
            8'h13, 8'h0C, 8'h3C, 8'h6C, 8'hBC, 8'hEC: isRead = 1'b1;
            default: isRead = 1'b0;
        endcase
    endfunction

    // lanes used for address (addrPhase) or for data
    function automatic logic [3:0] lanesOf(input logic [7:0] op, input logic quad4,
                                           input logic addrPhase);
        if (quad4) begin
            lanesOf = 4'h4;
        end else begin
            case (op)
                8'hBB, 8'hBC, 8'hBD: lanesOf = 4'h2;
                8'hEB, 8'hEC, 8'hED: lanesOf = 4'h4;
                8'h3B, 8'h3C: lanesOf = addrPhase ? 4'h1 : 4'h2;
                8'h6B, 8'h6C: lanesOf = addrPhase ? 4'h1 : 4'h4;
                default: lanesOf = 4'h1;
            endcase
        end
    endfunction

    function automatic logic isDtr(input logic [7:0] op);
        isDtr = (op == 8'h0D) || (op == 8'hBD) || (op == 8'hED);
    endfunction

    function automatic logic isAddr4Only(input logic [7:0] op);
        case (op)
            8'h13, 8'h0C, 8'h3C, 8'h6C, 8'hBC, 8'hEC: isAddr4Only = 1'b1;
            default: isAddr4Only = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    sfq_pkg::sfq_phase_type phase_q, phase_d;
    logic [7:0] opcSh_q, opcSh_d;        // opcode being shifted in
    logic [5:0] bitCnt_q, bitCnt_d;      // bits taken in this phase
    logic [31:0] addrSh_q, addrSh_d;
    logic addr4_q, addr4_d;              // this frame takes four bytes
    logic dtr_q, dtr_d;
    logic [3:0] lanes_q, lanes_d;        // lanes of the current phase
    logic quad4_q, quad4_d;
    logic addrW_q, addrW_d;
    logic init_q, init_d;                // first cycle after reset release or after a software reset
    logic resetArm_q, resetArm_d;
    logic [12:0] busyCnt_q, busyCnt_d;
    logic busy_q, busy_d;                // registered copy of busy for the status pin
    logic [8:0] hwLowCnt_q, hwLowCnt_d;
    logic pause_q, pause_d;
    logic sclkPrev_q;                    // previous synchronised clock level
    logic [7:0] outSh_q, outSh_d;
    logic [3:0] outCnt_q, outCnt_d;      // edges left in current byte
    logic [3:0] ioOut_q, ioOut_d, ioOe_q, ioOe_d;
    logic readTake_q, readTake_d, cmdValid_q, cmdValid_d;
    logic [7:0] cmdOpcode_q, cmdOpcode_d;
    logic addrValid_q, addrValid_d;
    logic [31:0] cmdAddr_q, cmdAddr_d;

    // ------------------------------------------------------------------------
    // pin roles, reset and pause conditions
    // ------------------------------------------------------------------------
    logic selected, sclkRise, sclkFall, pauseEn, hwLow, hwHit, blocked;
    logic [3:0] inLanes;
    logic [5:0] nextCnt;
    logic [7:0] opcNext;
    logic [7:0] word;
    localparam logic [3:0] LANE_OFF = sfq_pkg::LANES_NONE; // every lane released

    assign selected = !pins.selN;
    // shared pin carries reset only with quad_enable low and the role bit set
    assign hwLow = !pins.rstPinN
                 || (!quadEnable && pauseOrResetSel && !pins.io[3]);
    assign hwHit = hwLowCnt_q >= 9'(sfq_pkg::HW_RESET_CYCLES);
    assign blocked = hwLow || (busyCnt_q != 13'h0);
    // pause pin exists only in standard and dual operation
    assign pauseEn = selected && !quadEnable && !pauseOrResetSel && !quad4_q;
    // edges are seen only while selected and not paused
    assign sclkRise = selected && !pause_q && pins.sclk && !sclkPrev_q;
    assign sclkFall = selected && !pause_q && !pins.sclk && sclkPrev_q;
    assign inLanes = (phase_q == sfq_pkg::PH_OPCODE) ? (quad4_q ? 4'h4 : 4'h1) : lanes_q;
    assign nextCnt = bitCnt_q + {2'h0, inLanes};
    assign opcNext = quad4_q ? {opcSh_q[3:0], pins.io} : {opcSh_q[6:0], pins.io[0]};

    // ------------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        phase_d = phase_q;
        opcSh_d = opcSh_q;
        bitCnt_d = bitCnt_q;
        addrSh_d = addrSh_q;
        addr4_d = addr4_q;
        dtr_d = dtr_q;
        lanes_d = lanes_q;
        quad4_d = quad4_q;
        addrW_d = init_q ? addrWidthAtPowerup : addrW_q;
        init_d = 1'b0;
        resetArm_d = resetArm_q;
        busyCnt_d = (busyCnt_q != 13'h0) ? busyCnt_q - 13'h1 : 13'h0;
        hwLowCnt_d = !hwLow ? 9'h0 : (hwHit ? hwLowCnt_q : hwLowCnt_q + 9'h1);
        outSh_d = outSh_q;
        outCnt_d = outCnt_q;
        ioOut_d = ioOut_q;
        readTake_d = 1'b0;
        cmdValid_d = 1'b0;
        cmdOpcode_d = cmdOpcode_q;
        addrValid_d = 1'b0;
        cmdAddr_d = cmdAddr_q;
        word = (outCnt_q == 4'h0) ? readData : outSh_q;
        // pause follows the pin only while the clock is low
        pause_d = !pauseEn ? 1'b0 : (!pins.sclk ? !pins.io[3] : pause_q);
        if (!selected) begin
            // deselect ends the frame; mode bits survive
            phase_d = sfq_pkg::PH_OPCODE;
            bitCnt_d = 6'h0;
            outCnt_d = 4'h0;
        end else begin
            case (phase_q)
                sfq_pkg::PH_OPCODE: begin
                    if (sclkRise) begin
                        opcSh_d = opcNext;
                        bitCnt_d = nextCnt;
                        if (nextCnt == 6'(sfq_pkg::OPC_FRAME_BITS)) begin
                            bitCnt_d = 6'h0;
                            phase_d = sfq_pkg::PH_IGNORE;
                            if (!blocked) begin
                                cmdValid_d = 1'b1;
                                cmdOpcode_d = opcNext;
                                resetArm_d = (opcNext == sfq_pkg::OP_RESET_ARM);
                                case (opcNext)
                                    sfq_pkg::OP_ENTER_QUAD4: quad4_d = quadEnable ? 1'b1 : quad4_q;
                                    sfq_pkg::OP_EXIT_QUAD4: quad4_d = 1'b0;
                                    sfq_pkg::OP_ADDR4_ENTER: addrW_d = 1'b1;
                                    sfq_pkg::OP_ADDR4_EXIT: addrW_d = 1'b0;
                                    sfq_pkg::OP_RESET_GO: begin
                                        if (resetArm_q) begin
                                            busyCnt_d = 13'(SW_RESET_CYCLES);
                                            quad4_d = 1'b0;
                                            init_d = 1'b1;
                                        end
                                    end
                                    default: begin
                                    end
                                endcase
                                // quad reads need quad_enable; else ignored
                                if (isRead(opcNext) && (quadEnable ||
                                    lanesOf(opcNext, quad4_q, 1'b0) != 4'h4)) begin
                                    phase_d = sfq_pkg::PH_ADDR;
                                    lanes_d = lanesOf(opcNext, quad4_q, 1'b1);
                                    dtr_d = isDtr(opcNext);
                                    addr4_d = addrW_q || isAddr4Only(opcNext);
                                end
                            end
                        end
                    end
                end
                sfq_pkg::PH_ADDR: begin
                    // address on rising edges, both edges for DTR
                    if (sclkRise || (dtr_q && sclkFall)) begin
                        case (lanes_q)
                            4'h2: addrSh_d = {addrSh_q[29:0], pins.io[1:0]};
                            4'h4: addrSh_d = {addrSh_q[27:0], pins.io};
                            default: addrSh_d = {addrSh_q[30:0], pins.io[0]};
                        endcase
                        bitCnt_d = nextCnt;
                        if (nextCnt == (addr4_q ? 6'h20 : 6'h18)) begin
                            bitCnt_d = 6'h0;
                            addrValid_d = 1'b1;
                            // 3-byte mode borrows the top byte
                            cmdAddr_d = addr4_q ? addrSh_d : {extAddr, addrSh_d[23:0]};
                            phase_d = sfq_pkg::PH_DATA;
                            lanes_d = lanesOf(cmdOpcode_q, quad4_q, 1'b0);
                            outCnt_d = 4'h0;
                        end
                    end
                end
                sfq_pkg::PH_DATA: begin
                    // data leaves on falling edges, both edges for DTR
                    if (sclkFall || (dtr_q && sclkRise)) begin
                        readTake_d = (outCnt_q == 4'h0);
                        case (lanes_q)
                            4'h2: begin
                                ioOut_d = {2'h0, word[7:6]};
                                outSh_d = {word[5:0], 2'h0};
                                outCnt_d = (outCnt_q == 4'h0) ? 4'h3 : outCnt_q - 4'h1;
                            end
                            4'h4: begin
                                ioOut_d = word[7:4];
                                outSh_d = {word[3:0], 4'h0};
                                outCnt_d = (outCnt_q == 4'h0) ? 4'h1 : outCnt_q - 4'h1;
                            end
                            default: begin
                                ioOut_d = {2'h0, word[7], 1'b0};
                                outSh_d = {word[6:0], 1'b0};
                                outCnt_d = (outCnt_q == 4'h0) ? 4'h7 : outCnt_q - 4'h1;
                            end
                        endcase
                    end
                end
                default: begin
                    // rest of a frame not handled here is dropped
                end
            endcase
        end
        // output enables: only data phase, selected, not paused
        ioOe_d = LANE_OFF;
        if (selected && !pause_d && phase_q == sfq_pkg::PH_DATA && !hwLow) begin
            case (lanes_q)
                4'h2: ioOe_d = 4'h3;
                4'h4: ioOe_d = 4'hF;
                default: ioOe_d = 4'h2;
            endcase
        end
        // a long enough reset pulse restores the power-on state
        if (hwHit) begin
            phase_d = sfq_pkg::PH_OPCODE;
            bitCnt_d = 6'h0;
            quad4_d = 1'b0;
            addrW_d = addrWidthAtPowerup;
            resetArm_d = 1'b0;
            busyCnt_d = 13'h0;
            pause_d = 1'b0;
            cmdValid_d = 1'b0;
            ioOe_d = LANE_OFF;
        end
        // flag follows the counter value it will hold, so the pin needs no compare
        busy_d = (busyCnt_d != 13'h0);
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            phase_q <= sfq_pkg::PH_OPCODE;
            opcSh_q <= 8'h00;
            bitCnt_q <= 6'h0;
            addrSh_q <= 32'h0;
            addr4_q <= 1'b0;
            dtr_q <= 1'b0;
            lanes_q <= 4'h1;
            quad4_q <= 1'b0;
            addrW_q <= 1'b0;
            init_q <= 1'b1;
            resetArm_q <= 1'b0;
            busyCnt_q <= 13'h0;
            busy_q <= 1'b0;
            hwLowCnt_q <= 9'h0;
            pause_q <= 1'b0;
            sclkPrev_q <= 1'b0;
            outSh_q <= 8'h00;
            outCnt_q <= 4'h0;
            ioOut_q <= 4'h0;
            ioOe_q <= 4'h0;
            readTake_q <= 1'b0;
            cmdValid_q <= 1'b0;
            cmdOpcode_q <= 8'h00;
            addrValid_q <= 1'b0;
            cmdAddr_q <= 32'h0;
        end else begin
            phase_q <= phase_d;
            opcSh_q <= opcSh_d;
            bitCnt_q <= bitCnt_d;
            addrSh_q <= addrSh_d;
            addr4_q <= addr4_d;
            dtr_q <= dtr_d;
            lanes_q <= lanes_d;
            quad4_q <= quad4_d;
            addrW_q <= addrW_d;
            init_q <= init_d;
            resetArm_q <= resetArm_d;
            busyCnt_q <= busyCnt_d;
            busy_q <= busy_d;
            hwLowCnt_q <= hwLowCnt_d;
            pause_q <= pause_d;
            sclkPrev_q <= pins.sclk;
            outSh_q <= outSh_d;
            outCnt_q <= outCnt_d;
            ioOut_q <= ioOut_d;
            ioOe_q <= ioOe_d;
            readTake_q <= readTake_d;
            cmdValid_q <= cmdValid_d;
            cmdOpcode_q <= cmdOpcode_d;
            addrValid_q <= addrValid_d;
            cmdAddr_q <= cmdAddr_d;
        end
    end

    assign ioOut = ioOut_q;
    assign ioOe = ioOe_q;
    assign readTake = readTake_q;
    assign cmdValid = cmdValid_q;
    assign cmdOpcode = cmdOpcode_q;
    assign addrValid = addrValid_q;
    assign cmdAddr = cmdAddr_q;
    assign fourWireOpcodeMode = quad4_q;
    assign addrWidthNow = addrW_q;
    assign resetBusy = busy_q;
    assign pauseActive = pause_q;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    sequence pauseReq;
        pauseEn && !pins.io[3] && !pins.sclk;
    endsequence

    desel_tristate_a: assert property (pins.selN |=> ioOe_q == 4'h0)
        else $error("outputs driven while deselected");
    pause_tristate_a: assert property (pause_q |-> ioOe_q == 4'h0)
        else $error("outputs driven during pause");
    pause_start_a: assert property (pauseReq |=> pause_q)
        else $error("pause did not start with clock low");
    quad4_enter_a: assert property ($rose(quad4_q) |-> $past(quadEnable))
        else $error("four-wire mode entered without quad enable");
    width_cmd_a: assert property (cmdValid_q && cmdOpcode_q == sfq_pkg::OP_ADDR4_ENTER
        |-> addrW_q ##1 addrW_q || hwHit)
        else $error("address width not set by enter command");
    busy_block_a: assert property (busyCnt_q != 13'h0 |=> !cmdValid_q)
        else $error("command accepted while reset busy");
    hw_reset_a: assert property (hwHit |=> !quad4_q && !cmdValid_q && ioOe_q == 4'h0)
        else $error("hardware reset did not restore power-on state");
    frame_end_a: assert property ($rose(pins.selN) |=> phase_q == sfq_pkg::PH_OPCODE
        && bitCnt_q == 6'h0)
        else $error("frame not ended by deselect");
endmodule // sfq_front_end

/* File: design/sfq_pkg.sv */
// ----------------------------------------------------------------------------
// shared constants of the serial flash front end
// ----------------------------------------------------------------------------
package sfq_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 4;                   // 250 MHz core clock
    localparam int SW_RESET_TIME_NS = 30000;            // software reset busy time
    localparam int SW_RESET_CYCLES = SW_RESET_TIME_NS / CLK_PERIOD_NS;
    localparam int HW_RESET_MIN_NS = 1000;              // least low time of reset pin
    localparam int HW_RESET_CYCLES = (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // opcodes that the front end itself acts on
    localparam logic [7:0] OP_ENTER_QUAD4 = 8'h38;
    localparam logic [7:0] OP_EXIT_QUAD4 = 8'hFF;
    localparam logic [7:0] OP_ADDR4_ENTER = 8'hB7;
    localparam logic [7:0] OP_ADDR4_EXIT = 8'hE9;
    localparam logic [7:0] OP_RESET_ARM = 8'h66;
    localparam logic [7:0] OP_RESET_GO = 8'h99;

    // values after reset, and the opcode frame length
    localparam logic [6:0] PIN_IDLE = 7'h6F;            // {rstN, selN, sclk, io[3:0]}
    localparam logic [3:0] LANES_NONE = 4'h0;
    localparam logic [7:0] OPC_FRAME_BITS = 8'h08;      // opcode length in bits

    // frame phases
    typedef enum logic [1:0] {PH_OPCODE, PH_ADDR, PH_DATA, PH_IGNORE} sfq_phase_type;
endpackage

/* File: design/sfq_pin_if.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// synchronised pin levels passed from the synchroniser to the front end
// ----------------------------------------------------------------------------
interface sfq_pin_if;
    logic sclk;       // serial clock level
    logic selN;       // select, active low
    logic rstPinN;    // dedicated reset pin, active low
    logic [3:0] io;   // data line levels
    modport drv(output sclk, output selN, output rstPinN, output io);
    modport rcv(input sclk, input selN, input rstPinN, input io);
endinterface // sfq_pin_if

/* File: design/sfq_pin_sync.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// two flip-flop synchroniser for every pin
// ----------------------------------------------------------------------------
module sfq_pin_sync (
    input wire logic clk,
    input wire logic rstN,
    input wire logic sclkPin,
    input wire logic selectPinN,
    input wire logic resetPinN,
    input wire logic [3:0] ioIn,
    sfq_pin_if.drv pins
);
    logic [6:0] meta_q;   // first stage, read only by the second
    logic [6:0] sync_q;   // second stage, safe to use

    // both stages only register; idle levels after reset
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            meta_q <= sfq_pkg::PIN_IDLE;
            sync_q <= sfq_pkg::PIN_IDLE;
        end else begin
            meta_q <= {resetPinN, selectPinN, sclkPin, ioIn};
            sync_q <= meta_q;
        end
    end

    assign pins.rstPinN = sync_q[6];
    assign pins.selN = sync_q[5];
    assign pins.sclk = sync_q[4];
    assign pins.io = sync_q[3:0];
endmodule // sfq_pin_sync

/* File: bench/sfq_host_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// host controller: mode 0 or 3, half period of 20 core clocks
// ------------------------------------------------------------
module sfq_host_model (
    input wire logic clk,
    input wire logic [3:0] line,
    output logic sclk,
    output logic selN,
    output logic [3:0] io
);
    logic idleHigh = 1'b0; // clock level between frames: 0 mode 0, 1 mode 3
    initial begin
        sclk = 1'b0;
        selN = 1'b1;
        io = 4'hF;
    end
    task automatic begin_f();
        @(negedge clk);
        sclk = idleHigh; // idle level at both select edges
        io = 4'hF; // pause_n high, so selecting starts no pause
        @(negedge clk);
        selN = 1'b0; // select stays low for the whole frame
        repeat (20) @(negedge clk);
    endtask
    task automatic end_f();
        repeat (20) @(negedge clk);
        selN = 1'b1;
        io = ~io; // released lines must not show the last value
    endtask
    // data set while low, taken by the device on the rise
    task automatic shift(input logic [31:0] v, input int n, input int w, inout logic [7:0] cap);
        for (int i = n; i > 0; i -= w) begin
            if (idleHigh) begin
                sclk = 1'b0; // mode 3 opens each bit with a fall
            end
            io = (w == 4) ? v[i-1 -: 4] : {3'b111, v[i-1]};
            repeat (20) @(negedge clk);
            sclk = 1'b1;
            cap = {cap[6:0], line[1]};
            repeat (20) @(negedge clk);
            if (!idleHigh) begin
                sclk = 1'b0;
            end
        end
    endtask
endmodule // sfq_host_model

/* File: bench/serial_flash_spi_qpi_front_end_tb_top.sv */
`timescale 1ns/1ns
module serial_flash_spi_qpi_front_end_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic quadEnable = 1'b0;
    logic awp = 1'b0;
    logic [7:0] extAddr = 8'h00;
    logic [7:0] readData = 8'h00;
    logic [31:0] addr;
    logic [7:0] cap;
    wire sclk, selN, readTake, cmdValid, addrValid, qpiMode, addrWidthNow, resetBusy, pauseActive;
    wire [3:0] hostIo, ioOut, ioOe, line;
    wire [7:0] cmdOpcode;
    wire [31:0] cmdAddr;
    int n_errors = 0;
    int samples_checked = 0;
    logic rstPinN = 1'b1;
    logic pinRoleSel = 1'b0;
    int nCmd = 0, nAddr = 0, nTake = 0, n0 = 0;
    // wire level: device drives where enabled, host elsewhere
    assign line = (ioOe & ioOut) | (~ioOe & hostIo);
    always #2 clk = ~clk;
    sfq_host_model host (.clk(clk), .line(line), .sclk(sclk), .selN(selN), .io(hostIo));
    sfq_front_end #(.SW_RESET_CYCLES(400)) uut (.clk(clk), .arst_n(arst_n), .sclkPin(sclk),
        .selectPinN(selN), .resetPinN(rstPinN), .ioIn(line), .ioOut(ioOut), .ioOe(ioOe),
        .quadEnable(quadEnable), .pauseOrResetSel(pinRoleSel), .addrWidthAtPowerup(awp),
        .extAddr(extAddr), .readData(readData), .readTake(readTake), .cmdValid(cmdValid),
        .cmdOpcode(cmdOpcode), .addrValid(addrValid), .cmdAddr(cmdAddr),
        .fourWireOpcodeMode(qpiMode), .addrWidthNow(addrWidthNow), .resetBusy(resetBusy),
        .pauseActive(pauseActive));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic op(input logic [7:0] c, input int w);
        host.begin_f();
        host.shift({24'h0, c}, 8, w, cap);
        host.end_f();
    endtask
    // pulse counters, sampled mid-cycle where the pulses are settled
    always @(negedge clk) begin
        nCmd += cmdValid;
        nAddr += addrValid;
        nTake += readTake;
    end
    // watchdog well beyond the expected run
    initial begin
        #300000;
        n_errors++;
        final_report();
    end
    initial begin
        void'($urandom(90482));
        awp = 1'($urandom);
        extAddr = 8'($urandom);
        readData = 8'($urandom);
        addr = $urandom;
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        repeat (10) @(negedge clk);
        check(qpiMode, 0);
        check(addrWidthNow, awp);
        op(8'hB7, 1);
        check(addrWidthNow, 1);
        host.idleHigh = 1'b1;
        op(8'hE9, 1);
        check(addrWidthNow, 0);
        host.idleHigh = 1'b0;
        $display("test width done");
        host.begin_f();
        host.shift({24'h0, 8'h03}, 8, 1, cap);
        host.shift(addr, 24, 1, cap);
        check(cmdOpcode, 8'h03);
        check(cmdAddr, {extAddr, addr[23:0]});
        host.shift(0, 4, 1, cap);
        host.io = 4'h7; // pause_n low while the clock is low
        repeat (8) @(negedge clk);
        check(pauseActive, 1);
        host.sclk = 1'b1; // a clock pulse during the pause must be ignored
        repeat (20) @(negedge clk);
        check(ioOe, 4'h0);
        host.sclk = 1'b0;
        repeat (20) @(negedge clk);
        host.io = 4'hF;
        repeat (8) @(negedge clk);
        check(pauseActive, 0);
        host.shift(0, 4, 1, cap);
        check(cap, readData);
        check(ioOe, 4'h2);
        host.end_f();
        repeat (10) @(negedge clk);
        check(ioOe, 4'h0);
        check(nCmd, 3);
        check(nAddr, 1);
        check(nTake, 2);
        $display("test read done");
        op(8'h38, 1);
        check(qpiMode, 0);
        quadEnable = 1'b1;
        op(8'h38, 1);
        check(qpiMode, 1);
        op(8'hFF, 4);
        check(qpiMode, 0);
        $display("test mode done");
        op(8'hB7, 1);
        op(8'h38, 1);
        op(8'h66, 4);
        op(8'h99, 4);
        check(resetBusy, 1);
        check(qpiMode, 0);
        check(addrWidthNow, awp);
        n0 = nCmd;
        op(8'h38, 1);
        check(qpiMode, 0);
        check(nCmd, n0);
        repeat (400) @(negedge clk);
        check(resetBusy, 0);
        $display("test soft reset done");
        op(8'hB7, 1);
        rstPinN = 1'b0;
        n0 = nCmd;
        op(8'h38, 1);
        check(nCmd, n0);
        check(qpiMode, 0);
        check(addrWidthNow, awp);
        rstPinN = 1'b1;
        quadEnable = 1'b0;
        pinRoleSel = 1'b1;
        op(8'hB7, 1);
        check(addrWidthNow, 1);
        // released io3 reads low, which the shared pin now takes as reset
        repeat (300) @(negedge clk);
        check(addrWidthNow, awp);
        quadEnable = 1'b1;
        op(8'hB7, 1);
        repeat (300) @(negedge clk);
        check(addrWidthNow, 1);
        pinRoleSel = 1'b0;
        $display("test reset pin done");
        final_report();
    end
endmodule // serial_flash_spi_qpi_front_end_tb_top
